//--- hw/lms_loop_status.sv
// module: loop message response, status byte and service request logic
`timescale 1ns/10ps
`default_nettype none
module lms_loop_status (
    // clock and reset
    input  wire logic       CLK_SYS,
    input  wire logic       RST,
    // loop messages, one-cycle pulses from the loop logic, plus the listen-addressed level
    input  wire logic       MSG_TRIGGER,
    input  wire logic       MSG_CLEAR,
    input  wire logic       MSG_REMOTE,
    input  wire logic       MSG_LOCAL,
    input  wire logic       MSG_LOCKOUT,
    input  wire logic       MSG_CLEAR_LOCKOUT,
    input  wire logic       MSG_SERIAL_POLL,
    input  wire logic       LISTEN_ADDRESSED,
    // mask program code, pulse with two octal digits
    input  wire logic       MASK_WRITE,
    input  wire logic [5:0] MASK_CODE,
    // front panel buttons and other trigger sources, raw pins
    input  wire logic       BTN_LOCAL,
    input  wire logic       BTN_SRQ,
    input  wire logic       BTN_OTHER,
    input  wire logic       PANEL_TRIGGER,
    input  wire logic       POWER_ON_SRQ_SWITCH,
    // measurement side events, same clock
    input  wire logic       MEAS_DONE,
    input  wire logic       READING_READY,
    input  wire logic       READING_TAKEN,
    input  wire logic       READING_LOST,
    input  wire logic       RANGE_INVALID,
    input  wire logic       RANGE_VALID,
    input  wire logic       CODE_INVALID,
    input  wire logic       SELFTEST_FAIL,
    input  wire logic       CONVERTER_FAIL,
    input  wire logic       CHECKSUM_FAIL,
    input  wire logic       CAL_FAIL,
    // outputs
    output logic            MEAS_START,
    output logic            MEAS_BUSY,
    output logic            CONFIG_RESTORE,
    output logic            PANEL_ENABLE,
    output logic            PANEL_KEY,
    output logic            REMOTE_INDICATOR,
    output logic            SRQ_INDICATOR,
    output logic            SRQ_OUT,
    output logic [7:0]      SERVICE_CONDITION_BYTE,
    output logic [7:0]      SRQ_MASK
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage read only by the second stage
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic [4:0] sync_c;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
            sync_c <= 5'h00;
        end else begin
            sync_a <= {POWER_ON_SRQ_SWITCH, PANEL_TRIGGER, BTN_OTHER, BTN_SRQ, BTN_LOCAL};
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    logic pwr_sw;
    logic press_local;
    logic press_srq;
    logic press_other;
    logic press_trig;
    // edge detection on the synchronised level, so a held button acts once
    assign pwr_sw      = sync_b[4];
    assign press_local = sync_b[0] & ~sync_c[0];
    assign press_srq   = sync_b[1] & ~sync_c[1];
    assign press_other = sync_b[2] & ~sync_c[2];
    assign press_trig  = sync_b[3] & ~sync_c[3];

    ////////////////////////////////////////////////////////////////////////////
    // remote / lockout state
    lms_pkg::lms_rl_e rl;
    lms_pkg::lms_rl_e next_rl;
    logic             is_remote;
    logic             is_locked;
    logic             local_ok;
    logic             srq_ok;
    logic             other_ok;

    assign is_remote = (rl == lms_pkg::LMS_REMOTE) || (rl == lms_pkg::LMS_REMOTE_LOCK);
    assign is_locked = (rl == lms_pkg::LMS_REMOTE_LOCK) || (rl == lms_pkg::LMS_LOCAL_LOCK);
    // button gating: remote blocks ordinary keys, remote plus lockout blocks all
    assign other_ok = ~is_remote;
    assign local_ok = ~(is_remote & is_locked);
    assign srq_ok   = ~(is_remote & is_locked);

    // clear-lockout wins over local, which wins over lockout; in the local states remote is taken even with local in the same cycle
    always_comb begin
        next_rl = rl;
        unique case (rl)
            lms_pkg::LMS_LOCAL: begin
                if (MSG_REMOTE) next_rl = lms_pkg::LMS_REMOTE;
            end
            lms_pkg::LMS_REMOTE: begin
                if (MSG_LOCAL || MSG_CLEAR_LOCKOUT || (press_local && local_ok)) begin
                    next_rl = lms_pkg::LMS_LOCAL;
                end else if (MSG_LOCKOUT) begin
                    next_rl = lms_pkg::LMS_REMOTE_LOCK;
                end
            end
            lms_pkg::LMS_REMOTE_LOCK: begin
                if (MSG_CLEAR_LOCKOUT) next_rl = lms_pkg::LMS_LOCAL;
                else if (MSG_LOCAL) next_rl = lms_pkg::LMS_LOCAL_LOCK;
            end
            lms_pkg::LMS_LOCAL_LOCK: begin
                if (MSG_CLEAR_LOCKOUT) next_rl = lms_pkg::LMS_LOCAL;
                else if (MSG_REMOTE) next_rl = lms_pkg::LMS_REMOTE_LOCK;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) rl <= lms_pkg::LMS_LOCAL;
        else     rl <= next_rl;
    end

    ////////////////////////////////////////////////////////////////////////////
    // status byte, mask and request
    logic [7:0] status;
    logic [7:0] next_status;
    logic [7:0] mask;
    logic [7:0] next_mask;
    logic       srq;
    logic       next_srq;
    // one-hot walk of the first three edges after reset; the top bit marks the
    // cycle in which the switch has first crossed the synchroniser
    logic [2:0] pwr_pending;
    logic [2:0] next_pwr_pending;
    logic       rqs;

    // request flag is any status bit with its mask bit, plus the power-on bit
    function automatic logic req_match(input logic [7:0] st, input logic [7:0] mk);
        req_match = (|(st[5:0] & mk[5:0])) | st[lms_pkg::BIT_POWER_ON];
    endfunction

    always_comb begin
        next_pwr_pending = {pwr_pending[1:0], 1'b0};
        next_status      = status;
        next_mask        = mask;
        // a serial poll clears the transient bits first, new events then win
        if (MSG_SERIAL_POLL) next_status = status & ~lms_pkg::POLL_CLEAR_BITS;
        // power-on bit, caught once the switch level is through both sync stages;
        // reading it earlier would see the reset zero and lose the power-on request
        if (pwr_pending[2] && pwr_sw) next_status[lms_pkg::BIT_POWER_ON] = 1'b1;
        if (READING_TAKEN || READING_LOST) begin
            next_status[lms_pkg::BIT_DATA_READY] = 1'b0;
        end else if (READING_READY) begin
            next_status[lms_pkg::BIT_DATA_READY] = 1'b1;
        end
        if (RANGE_INVALID) next_status[lms_pkg::BIT_BAD_RANGE] = 1'b1;
        else if (RANGE_VALID) next_status[lms_pkg::BIT_BAD_RANGE] = 1'b0;
        if (CODE_INVALID) next_status[lms_pkg::BIT_SYNTAX] = 1'b1;
        // internal error has no clear of its own until a device clear
        if (SELFTEST_FAIL || CONVERTER_FAIL || CHECKSUM_FAIL) begin
            next_status[lms_pkg::BIT_INTERNAL] = 1'b1;
        end
        if (press_srq && srq_ok) next_status[lms_pkg::BIT_PANEL_SRQ] = 1'b1;
        if (CAL_FAIL) next_status[lms_pkg::BIT_CAL_FAIL] = 1'b1;
        if (MASK_WRITE) begin
            next_mask = {2'b00, MASK_CODE} & lms_pkg::MASK_PROG_BITS;
        end
        // device clear returns the status to its reset value; power-on bit and mask bit 7 follow the switch
        if (MSG_CLEAR) begin
            next_status = lms_pkg::STATUS_RESET;
            next_status[lms_pkg::BIT_POWER_ON] = pwr_sw;
            next_mask = pwr_sw ? lms_pkg::MASK_POWER_ON : lms_pkg::MASK_CLEAR;
        end
        next_status[lms_pkg::BIT_RQS] = 1'b0;
    end

    // flag: mask gates every condition except power-on
    assign rqs = req_match(next_status, next_mask);

    always_comb begin
        next_srq = srq;
        if (MSG_SERIAL_POLL) next_srq = 1'b0;
        // data taken or lost withdraws the request unless another condition still asks
        if ((READING_TAKEN || READING_LOST) && !rqs) next_srq = 1'b0;
        // rising flag raises the request; it holds until a poll, a device clear or the withdrawal above
        if (rqs && !req_match(status, mask)) next_srq = 1'b1;
        if (MSG_CLEAR) next_srq = rqs;
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            status      <= lms_pkg::STATUS_RESET;
            mask        <= lms_pkg::MASK_CLEAR;
            srq         <= 1'b0;
            pwr_pending <= 3'h1;
        end else begin
            status      <= next_status;
            mask        <= next_mask;
            srq         <= next_srq;
            pwr_pending <= next_pwr_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // measurement trigger: loop trigger has priority and restarts a busy cycle
    logic busy;
    logic next_busy;
    logic start;
    logic next_start;
    logic loop_trig;

    assign loop_trig = MSG_TRIGGER & LISTEN_ADDRESSED;

    always_comb begin
        next_start = 1'b0;
        next_busy  = busy;
        if (loop_trig) begin
            next_start = 1'b1;
            next_busy  = 1'b1;
        end else if (press_trig && other_ok && !busy) begin
            next_start = 1'b1;
            next_busy  = 1'b1;
        end else if (MEAS_DONE) begin
            next_busy = 1'b0;
        end
        if (MSG_CLEAR) begin
            next_start = 1'b0;
            next_busy  = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            busy  <= 1'b0;
            start <= 1'b0;
        end else begin
            busy  <= next_busy;
            start <= next_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            MEAS_START             <= 1'b0;
            MEAS_BUSY              <= 1'b0;
            CONFIG_RESTORE         <= 1'b0;
            PANEL_ENABLE           <= 1'b1;
            PANEL_KEY              <= 1'b0;
            REMOTE_INDICATOR       <= 1'b0;
            SRQ_INDICATOR          <= 1'b0;
            SRQ_OUT                <= 1'b0;
            SERVICE_CONDITION_BYTE <= lms_pkg::STATUS_RESET;
            SRQ_MASK               <= lms_pkg::MASK_CLEAR;
        end else begin
            MEAS_START       <= start;
            MEAS_BUSY        <= busy;
            // configuration is kept on entering remote; only a clear restores it
            CONFIG_RESTORE   <= MSG_CLEAR;
            PANEL_ENABLE     <= ~(next_rl == lms_pkg::LMS_REMOTE
                                 || next_rl == lms_pkg::LMS_REMOTE_LOCK);
            PANEL_KEY        <= press_other & other_ok;
            REMOTE_INDICATOR <= (next_rl == lms_pkg::LMS_REMOTE
                                 || next_rl == lms_pkg::LMS_REMOTE_LOCK);
            SRQ_INDICATOR    <= rqs;
            SRQ_OUT          <= next_srq;
            SERVICE_CONDITION_BYTE <= {next_status[7], rqs, next_status[5:0]};
            SRQ_MASK         <= next_mask;
        end
    end

endmodule
`default_nettype wire

//--- hw/lms_pkg.sv
// package: constants and types for the loop message, status and service request block
package lms_pkg;
    // status byte bit positions
    localparam int BIT_DATA_READY   = 0;
    localparam int BIT_BAD_RANGE    = 1;
    localparam int BIT_SYNTAX       = 2;
    localparam int BIT_INTERNAL     = 3;
    localparam int BIT_PANEL_SRQ    = 4;
    localparam int BIT_CAL_FAIL     = 5;
    localparam int BIT_RQS          = 6;
    localparam int BIT_POWER_ON     = 7;
    // mask values loaded on clear and reset
    localparam logic [7:0] MASK_CLEAR    = 8'h00;
    localparam logic [7:0] MASK_POWER_ON = 8'h80;
    // programmable mask bits 0 to 5 only
    localparam logic [7:0] MASK_PROG_BITS = 8'h3F;
    // bits cleared by a serial poll: 2, 4, 5, 7
    localparam logic [7:0] POLL_CLEAR_BITS = 8'hB4;
    // reset value of the sticky status bits
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // link state along the usual path, gray coded
    typedef enum logic [1:0] {
        LMS_LOCAL       = 2'b00,
        LMS_REMOTE      = 2'b01,
        LMS_REMOTE_LOCK = 2'b11,
        LMS_LOCAL_LOCK  = 2'b10
    } lms_rl_e;
endpackage

//--- sim/lms_ctrl_model.sv
// partner model: loop controller sending messages, mask codes and polls
`timescale 1ns/10ps
`default_nettype none
module lms_ctrl_model (
    // clock
    input  wire logic       clk,
    // trigger, clear, remote, local, lockout, clear lockout, poll
    output logic [6:0]      msg,
    // listen addressing and mask programming
    output logic            listen,
    output logic            mask_wr,
    output logic [5:0]      mask_code
);
    // idle loop: no message, not addressed
    initial begin
        msg = '0;
        listen = 1'b0;
        mask_wr = 1'b0;
        mask_code = 6'h2A;
    end
    // one message, one cycle wide, launched off the falling edge
    // an idle cycle follows, so back-to-back sends never touch msg twice in one step
    task automatic send(input int m);
        msg = 7'h01 << m;
        @(negedge clk);
        msg = 7'h00;
        @(negedge clk);
    endtask
    // a trigger only starts a measurement after addressing the device to listen
    task automatic address(input logic on);
        listen = on;
    endtask
    // two octal digits cover mask bits 0 to 5 only
    task automatic set_mask(input logic [5:0] code);
        mask_code = code;
        mask_wr = 1'b1;
        @(negedge clk);
        mask_wr = 1'b0;
        mask_code = ~code; // released code lines do not keep their value
    endtask
endmodule
`default_nettype wire

//--- sim/lms_loop_status_sva.sv
// checker: port-level properties of the loop status block
`timescale 1ns/10ps
`default_nettype none
module lms_loop_status_sva (
    // clock and reset
    input wire logic       CLK_SYS,
    input wire logic       RST,
    // loop side
    input wire logic       MSG_TRIGGER,
    input wire logic       MSG_CLEAR,
    input wire logic       MSG_REMOTE,
    input wire logic       MSG_LOCAL,
    input wire logic       MSG_CLEAR_LOCKOUT,
    input wire logic       MSG_SERIAL_POLL,
    input wire logic       LISTEN_ADDRESSED,
    input wire logic       MASK_WRITE,
    input wire logic [5:0] MASK_CODE,
    input wire logic       CODE_INVALID,
    // outputs watched
    input wire logic       MEAS_START,
    input wire logic       CONFIG_RESTORE,
    input wire logic       PANEL_ENABLE,
    input wire logic       REMOTE_INDICATOR,
    input wire logic       SRQ_INDICATOR,
    input wire logic       SRQ_OUT,
    input wire logic [7:0] SERVICE_CONDITION_BYTE,
    input wire logic [7:0] SRQ_MASK
);
    // short alias for the status byte
    wire logic [7:0] sb = SERVICE_CONDITION_BYTE;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    a_trig_start: assert property (MSG_TRIGGER && LISTEN_ADDRESSED && !MSG_CLEAR |-> ##[1:2] MEAS_START)
        else $error("listened trigger gave no start");
    a_clear_mask: assert property (MSG_CLEAR |=> CONFIG_RESTORE && (SRQ_MASK & 8'h7F) == 8'h00 && (sb & 8'h3F) == 8'h00)
        else $error("clear did not restore power-up state");
    a_remote_lamp: assert property (MSG_REMOTE && !MSG_CLEAR && !MSG_LOCAL && !MSG_CLEAR_LOCKOUT |=> REMOTE_INDICATOR && !PANEL_ENABLE)
        else $error("remote message not shown");
    a_clr_lockout: assert property (MSG_CLEAR_LOCKOUT && !MSG_REMOTE |=> !REMOTE_INDICATOR && PANEL_ENABLE)
        else $error("clear lockout did not go local");
    a_flag_lamp: assert property (SRQ_INDICATOR == sb[6])
        else $error("request lamp differs from flag");
    a_flag_match: assert property (sb[6] == (|(sb & SRQ_MASK & 8'h3F) || sb[7]))
        else $error("request flag differs from mask match");
    a_poll_clear: assert property (MSG_SERIAL_POLL && !MSG_CLEAR && !CODE_INVALID |=> !SRQ_OUT && (sb & 8'hA4) == 8'h00)
        else $error("poll left request or bits");
    a_srq_rise: assert property ($rose(sb[6]) |-> SRQ_OUT)
        else $error("request output late");
    a_mask_load: assert property (MASK_WRITE && !MSG_CLEAR |=> SRQ_MASK == {2'b00, $past(MASK_CODE)})
        else $error("mask code not loaded");
    a_code_bit: assert property (CODE_INVALID && !MSG_CLEAR |=> sb[2])
        else $error("syntax bit not set");
endmodule
bind lms_loop_status lms_loop_status_sva i_sva (.CLK_SYS, .RST, .MSG_TRIGGER, .MSG_CLEAR,
    .MSG_REMOTE, .MSG_LOCAL, .MSG_CLEAR_LOCKOUT, .MSG_SERIAL_POLL, .LISTEN_ADDRESSED,
    .MASK_WRITE, .MASK_CODE, .CODE_INVALID, .MEAS_START, .CONFIG_RESTORE, .PANEL_ENABLE,
    .REMOTE_INDICATOR, .SRQ_INDICATOR, .SRQ_OUT, .SERVICE_CONDITION_BYTE, .SRQ_MASK);
`default_nettype wire

//--- sim/testbench.sv
// testbench: directed scenarios for the loop status block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module testbench;
    logic            clk_sys = 1'b0;
    logic            rst = 1'b1;
    logic [10:0]     ev = '0;   // done, ready, taken, lost, bad, good, code, self, conv, sum, cal
    logic [4:0]      pin = '0;  // local, srq, other, panel trigger, power-on switch
    wire logic [6:0] msg;
    wire logic       listen, mask_wr;
    wire logic [5:0] mask_code;
    logic            meas_start, meas_busy, panel_en, panel_key, remote_indicator, srq_ind, srq_out;
    logic [7:0]      scb, mask;
    int              error_cnt = 0;
    int              checks_done = 0;
    int              starts = 0;
    int              keys = 0;
    // clock and watchdog
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        conclude;
    end
    // count one-cycle output pulses
    always @(posedge clk_sys) begin
        if (meas_start === 1'b1) starts++;
        if (panel_key === 1'b1) keys++;
    end
    lms_ctrl_model i_ctl (.clk(clk_sys), .msg(msg), .listen(listen), .mask_wr(mask_wr),
        .mask_code(mask_code));
    lms_loop_status i_dut (
        .CLK_SYS(clk_sys), .RST(rst), .MSG_TRIGGER(msg[0]), .MSG_CLEAR(msg[1]),
        .MSG_REMOTE(msg[2]), .MSG_LOCAL(msg[3]), .MSG_LOCKOUT(msg[4]),
        .MSG_CLEAR_LOCKOUT(msg[5]), .MSG_SERIAL_POLL(msg[6]), .LISTEN_ADDRESSED(listen),
        .MASK_WRITE(mask_wr), .MASK_CODE(mask_code), .BTN_LOCAL(pin[0]), .BTN_SRQ(pin[1]),
        .BTN_OTHER(pin[2]), .PANEL_TRIGGER(pin[3]), .POWER_ON_SRQ_SWITCH(pin[4]),
        .MEAS_DONE(ev[0]), .READING_READY(ev[1]), .READING_TAKEN(ev[2]),
        .READING_LOST(ev[3]), .RANGE_INVALID(ev[4]), .RANGE_VALID(ev[5]),
        .CODE_INVALID(ev[6]), .SELFTEST_FAIL(ev[7]), .CONVERTER_FAIL(ev[8]),
        .CHECKSUM_FAIL(ev[9]), .CAL_FAIL(ev[10]), .MEAS_START(meas_start),
        .MEAS_BUSY(meas_busy), .CONFIG_RESTORE(), .PANEL_ENABLE(panel_en),
        .PANEL_KEY(panel_key), .REMOTE_INDICATOR(remote_indicator), .SRQ_INDICATOR(srq_ind),
        .SRQ_OUT(srq_out), .SERVICE_CONDITION_BYTE(scb), .SRQ_MASK(mask));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic pulse(input int i);
        ev = 11'h001 << i;
        cyc(1);
        ev = 11'h000;
        cyc(1);
    endtask
    // pins pass a two-flop sync, so hold long enough to be seen
    task automatic press(input int i);
        pin = pin | (5'h01 << i);
        cyc(5);
        pin = pin & ~(5'h01 << i);
        cyc(5);
    endtask
    task automatic wait_start(input int n);
        for (int k = 0; k < 6 && starts < n; k++) cyc(1);
        `CHK(starts, n)
        if (starts != n) conclude;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_trigger;
        int s = starts;
        i_ctl.address(1'b1);
        i_ctl.send(0);
        wait_start(s + 1);
        `CHK(meas_busy, 1'b1)
        i_ctl.send(0);
        wait_start(s + 2);
        pulse(0);
        i_ctl.address(1'b0);
        i_ctl.send(0);
        cyc(4);
        `CHK(starts, s + 2)
        $display("test trigger done");
    endtask
    task automatic t_remote;
        int k = keys;
        int s = starts;
        i_ctl.send(2);
        `CHK({remote_indicator, panel_en}, 2'b10)
        press(2);
        press(3);
        `CHK(keys + starts, k + s)
        press(0);
        `CHK(remote_indicator, 1'b0)
        press(2);
        `CHK(keys, k + 1)
        i_ctl.send(2);
        i_ctl.send(4);
        press(0);
        press(1);
        `CHK({remote_indicator, scb[4]}, 2'b10)
        i_ctl.send(3);
        `CHK(remote_indicator, 1'b0)
        i_ctl.send(2);
        press(0);
        `CHK(remote_indicator, 1'b1)
        i_ctl.send(5);
        `CHK({remote_indicator, panel_en}, 2'b01)
        i_ctl.send(2);
        press(0);
        `CHK(remote_indicator, 1'b0)
        $display("test remote done");
    endtask
    task automatic t_status;
        for (int k = 7; k < 10; k++) begin
            pulse(k);
            `CHK(scb[3], 1'b1)
            i_ctl.send(1);
            `CHK(scb, 8'h00)
        end
        pulse(1);
        pulse(4);
        pulse(6);
        pulse(10);
        press(1);
        `CHK({srq_out, scb}, 9'h037)
        i_ctl.set_mask(6'h04);
        `CHK({srq_out, srq_ind, scb[6], mask}, 11'h704)
        i_ctl.send(6);
        `CHK({srq_out, scb}, 9'h003)
        pulse(2);
        pulse(5);
        `CHK(scb, 8'h00)
        i_ctl.set_mask(6'h01);
        pulse(1);
        i_ctl.set_mask(6'h00);
        `CHK(srq_out, 1'b1)
        pulse(3);
        `CHK({srq_out, scb}, 9'h000)
        pin[4] = 1'b1;
        cyc(4);
        i_ctl.send(1);
        `CHK({srq_out, scb, mask}, 17'h1C080)
        i_ctl.send(6);
        `CHK({srq_out, scb}, 9'h000)
        pin[4] = 1'b0;
        $display("test status done");
    endtask
    // mid-run reset with the power-on switch on: bit 7 must request service
    task automatic t_power;
        pin = 5'h10;
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(4);
        `CHK({srq_out, srq_ind, scb, mask}, 18'h3C000)
        i_ctl.send(6);
        `CHK({srq_out, scb}, 9'h000)
        pin = 5'h00;
        $display("test power done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(2);
        rst = 1'b0;
        cyc(4);
        `CHK({scb, mask, panel_en, remote_indicator, srq_out}, 19'h00004)
        t_trigger;
        t_remote;
        t_status;
        t_power;
        conclude;
    end
endmodule
`default_nettype wire
